// >>> ccr_pkg.sv
// Shared constants and types of the codec control register set and its serial link.
// Contract
// - Bits 12..8 address, bits 7..0 data.
// - Bit 13 low writes, high reads.
// - Address 0 no-op, 1 and 2 registers.
// - Primary bit 7 resets once, self-clears.
// - Primary bit 6 powers down analog, filters.
// - Primary bit 5 picks auxiliary converter input.
// - Primary bit 4 picks auxiliary monitor source.
// - Primary bits 3..2 set monitor gain.
// - Primary bit 1 enables digital loopback.
// - Primary bit 0 selects hardware secondary requests.
// - Both control registers reset to zero.
// - Secondary bit 5 reads filter overflow only.
// - Bits 4..3 read flags; bit 2 phone mode.
// - Host writes zeros to reserved bits; ccr_host sends the command word as written, without clearing them.
// - Sample words are two's complement.
package ccr_pkg;

  // ==========================================================================
  // Serial word layout.
  localparam int FRAME_BITS = 16;
  localparam int RW_BIT     = 13;
  localparam int ADDR_MSB   = 12;
  localparam int ADDR_LSB   = 8;
  localparam int DATA_MSB   = 7;
  localparam int HDR_BITS   = 8;
  localparam int CNT_W      = 5;

  // ==========================================================================
  // Device register addresses, layout and reset value.
  localparam logic [4:0] ADDR_NOP = 5'h00;
  localparam logic [4:0] ADDR_PRI = 5'h01;
  localparam logic [4:0] ADDR_SEC = 5'h02;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int P_SRST    = 7;
  localparam int P_PDN     = 6;
  localparam int P_INSEL   = 5;
  localparam int P_MONSEL  = 4;
  localparam int P_GAIN_HI = 3;
  localparam int P_GAIN_LO = 2;
  localparam int P_LOOP    = 1;
  localparam int P_HWSEC   = 0;
  localparam int S_OVF     = 5;
  localparam int S_FLAG1   = 4;
  localparam int S_FLAG0   = 3;
  localparam int S_PHONE   = 2;

  // Monitor amplifier settings as coded in bits 3..2.
  typedef enum logic [1:0] {
    MON_MUTE  = 2'h0,
    MON_0DB   = 2'h1,
    MON_M8DB  = 2'h2,
    MON_M18DB = 2'h3
  } ccr_gain_e;

  // ==========================================================================
  // Host controller APB map.
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_RDATA = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  localparam int CMD_SEC_BIT = 16;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_HWSEC  = 1;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_RDATA   = 1;
  localparam int IRQ_W       = 2;

  // ==========================================================================
  // Timing and reset values of the link.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS) < 1) ? 1 :
                                  SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // Synchroniser reset for {sclk, fs_n, din, sec_req}: frame sync idles high.
  localparam logic [3:0] LINK_SYNC_RST = 4'h4;

  // Host frame engine states, Gray coded along idle, run, gap.
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_RUN  = 2'h1,
    H_GAP  = 2'h3
  } ccr_hstate_e;

endpackage

// >>> ccr_link_if.sv
// Serial link between the host serial port and the codec control port.
`timescale 1ns/1ps
`default_nettype none
interface ccr_link_if;
  logic sclk;
  logic fs_n;
  logic din;
  logic sec_req;
  logic dout;
  logic dout_oe;
  logic dout_line;

  // The output line floats low when the codec does not drive it.
  assign dout_line = dout_oe & dout;

  modport host (
    output sclk,
    output fs_n,
    output din,
    output sec_req,
    input  dout_line
  );
  modport dev (
    input  sclk,
    input  fs_n,
    input  din,
    input  sec_req,
    output dout,
    output dout_oe
  );
endinterface
`default_nettype wire

// >>> ccr_sync.sv
// Two-stage synchroniser for pins that come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module ccr_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second, so metastability has a full cycle to settle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> ccr_dev.sv
// Codec end: serial control port with the two control registers and the sample path.
`timescale 1ns/1ps
`default_nettype none
module ccr_dev (
  input  wire logic        pclk,
  input  wire logic        presetn,
  ccr_link_if.dev          link,
  input  wire logic        fir_overflow,
  input  wire logic [1:0]  flag_level,
  input  wire logic [15:0] adc_sample,
  output logic             power_down,
  output logic             adc_aux_sel,
  output logic             mon_aux_sel,
  output logic [1:0]       mon_gain,
  output logic             loopback,
  output logic             hw_secondary,
  output logic             phone_mode,
  output logic             soft_reset,
  output logic [15:0]      dac_sample,
  output logic             dac_valid
);

  // ==========================================================================
  // Pin synchronisation and edge detection.
  logic [3:0]             pins_s;
  logic                   sclk_s;
  logic                   fs_s;
  logic                   din_s;
  logic                   sec_s;
  logic                   sclk_d_r;
  logic                   fs_d_r;
  logic                   rise;
  logic                   fall;
  logic                   frame_start;

  ccr_sync #(
    .W   (4),
    .RST (ccr_pkg::LINK_SYNC_RST)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({link.sclk, link.fs_n, link.din, link.sec_req}),
    .q     (pins_s)
  );

  assign sclk_s = pins_s[3];
  assign fs_s   = pins_s[2];
  assign din_s  = pins_s[1];
  assign sec_s  = pins_s[0];

  // Delayed copies of the synchronised clock and frame sync give their edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
      fs_d_r   <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      fs_d_r   <= fs_s;
    end
  end

  assign rise        = sclk_s & ~sclk_d_r;
  assign fall        = ~sclk_s & sclk_d_r;
  assign frame_start = ~fs_s & fs_d_r;

  // ==========================================================================
  // Receive shift register and bit counter.
  logic [ccr_pkg::CNT_W-1:0]      cnt_r;
  logic [ccr_pkg::FRAME_BITS-1:0] in_sh_r;
  logic [ccr_pkg::FRAME_BITS-1:0] word_now;
  logic [ccr_pkg::HDR_BITS-1:0]   hdr_now;
  logic                           hdr_done;
  logic                           word_done;

  // Bits are taken on the falling link clock edge, after the host set them up on the rising one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= '0;
      in_sh_r <= '0;
    end else if (fs_s) begin
      cnt_r <= '0;
    end else if (fall && cnt_r != ccr_pkg::CNT_W'(ccr_pkg::FRAME_BITS)) begin
      in_sh_r <= {in_sh_r[ccr_pkg::FRAME_BITS-2:0], din_s};
      cnt_r   <= cnt_r + 5'h01;
    end
  end

  assign word_now  = {in_sh_r[ccr_pkg::FRAME_BITS-2:0], din_s};
  assign hdr_now   = {in_sh_r[ccr_pkg::HDR_BITS-2:0], din_s};
  assign hdr_done  = fall & ~fs_s & (cnt_r == ccr_pkg::CNT_W'(ccr_pkg::HDR_BITS - 1));
  assign word_done = fall & ~fs_s & (cnt_r == ccr_pkg::CNT_W'(ccr_pkg::FRAME_BITS - 1));

  // ==========================================================================
  // Control registers.
  logic [7:0]             pri_r;
  logic                   phone_r;
  logic                   srst_r;
  logic [4:0]             wr_addr;
  logic [7:0]             wr_data;
  logic                   sec_write;

  assign wr_addr   = word_now[ccr_pkg::ADDR_MSB:ccr_pkg::ADDR_LSB];
  assign wr_data   = word_now[ccr_pkg::DATA_MSB:0];
  assign sec_write = word_done & sec_s & ~word_now[ccr_pkg::RW_BIT];

  // A write with the reset bit set pulses soft_reset for one cycle, restores the defaults and leaves the bit clear,
  // so the host never has to write a zero to end the reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_r   <= ccr_pkg::CTRL_RST;
      phone_r <= 1'b0;
      srst_r  <= 1'b0;
    end else begin
      srst_r <= 1'b0;
      if (sec_write) begin
        if (wr_addr == ccr_pkg::ADDR_PRI) begin
          if (wr_data[ccr_pkg::P_SRST]) begin
            srst_r  <= 1'b1;
            pri_r   <= ccr_pkg::CTRL_RST;
            phone_r <= 1'b0;
          end else begin
            pri_r <= {1'b0, wr_data[ccr_pkg::P_SRST-1:0]};
          end
        end else if (wr_addr == ccr_pkg::ADDR_SEC) begin
          phone_r <= wr_data[ccr_pkg::S_PHONE];
        end
      end
    end
  end

  // Register fields drive the analog controls directly.
  assign power_down   = pri_r[ccr_pkg::P_PDN];
  assign adc_aux_sel  = pri_r[ccr_pkg::P_INSEL];
  assign mon_aux_sel  = pri_r[ccr_pkg::P_MONSEL];
  assign mon_gain     = pri_r[ccr_pkg::P_GAIN_HI:ccr_pkg::P_GAIN_LO];
  assign loopback     = pri_r[ccr_pkg::P_LOOP];
  assign hw_secondary = pri_r[ccr_pkg::P_HWSEC];
  assign phone_mode   = phone_r;
  assign soft_reset   = srst_r;

  // ==========================================================================
  // Read data: status bits are sampled live when the address arrives.
  logic [7:0]             rd_data;
  logic [4:0]             rd_addr;

  assign rd_addr = hdr_now[ccr_pkg::ADDR_MSB-ccr_pkg::ADDR_LSB:0];

  // Reserved, write-only-ignored and unmapped positions all read back as zero.
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == ccr_pkg::ADDR_PRI) begin
      rd_data = pri_r;
    end else if (rd_addr == ccr_pkg::ADDR_SEC) begin
      rd_data[ccr_pkg::S_OVF]   = fir_overflow;
      rd_data[ccr_pkg::S_FLAG1] = flag_level[1];
      rd_data[ccr_pkg::S_FLAG0] = flag_level[0];
      rd_data[ccr_pkg::S_PHONE] = phone_r;
    end
  end

  // ==========================================================================
  // Sample path.
  logic [15:0]            dac_r;
  logic                   dac_valid_r;
  logic [15:0]            adc_word;

  // With the filters powered down no new sample is accepted; words are kept as two's complement.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_r       <= 16'h0000;
      dac_valid_r <= 1'b0;
    end else begin
      dac_valid_r <= 1'b0;
      if (word_done && !sec_s && !pri_r[ccr_pkg::P_PDN]) begin
        dac_r       <= word_now;
        dac_valid_r <= 1'b1;
      end
    end
  end

  assign dac_sample = dac_r;
  assign dac_valid  = dac_valid_r;

  // Loopback returns the last received sample; power down returns silence.
  assign adc_word = pri_r[ccr_pkg::P_PDN]  ? 16'h0000 :
                    pri_r[ccr_pkg::P_LOOP] ? dac_r : adc_sample;

  // ==========================================================================
  // Transmit side: one bit per rising link clock edge while the frame is open.
  logic [15:0]            out_sh_r;
  logic                   dout_r;
  logic                   oe_r;

  // A secondary frame sends zeros until the header is in, then the addressed register on a read and zeros on a write;
  // the reload at the header lands just before the ninth rising edge.
  // A primary frame must never take the reload, or the low byte of the sample would be lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sh_r <= 16'h0000;
      dout_r   <= 1'b0;
      oe_r     <= 1'b0;
    end else begin
      oe_r <= ~fs_s;
      if (fs_s) begin
        dout_r <= 1'b0;
      end else if (frame_start) begin
        dout_r   <= sec_s ? 1'b0 : adc_word[15];
        out_sh_r <= sec_s ? 16'h0000 : {adc_word[14:0], 1'b0};
      end else if (hdr_done && sec_s) begin
        out_sh_r <= hdr_now[ccr_pkg::RW_BIT-ccr_pkg::ADDR_LSB] ?
                    {rd_data, 8'h00} : 16'h0000;
      end else if (rise && cnt_r != ccr_pkg::CNT_W'(ccr_pkg::FRAME_BITS)) begin
        dout_r   <= out_sh_r[15];
        out_sh_r <= {out_sh_r[14:0], 1'b0};
      end
    end
  end

  assign link.dout    = dout_r;
  assign link.dout_oe = oe_r;

endmodule
`default_nettype wire

// >>> ccr_host.sv
// Host end: APB-controlled serial port master that issues codec frames.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ccr_host #(
  parameter int SCLK_HALF = ccr_pkg::SCLK_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  ccr_link_if.host         link
);

  // ==========================================================================
  // APB slave with one wait state, so read data leaves a flip-flop.
  logic                   acc;
  logic                   busy;
  logic                   mapped;
  logic [31:0]            rd_mux;
  logic [ccr_pkg::IRQ_W-1:0] istat_r;
  logic [ccr_pkg::IRQ_W-1:0] imask_r;
  logic [ccr_pkg::IRQ_W-1:0] ev_set;
  logic [15:0]            rdata_r;
  logic                   hwsec_r;

  assign acc    = psel & penable & pready;
  assign mapped = (paddr == ccr_pkg::OFS_CMD) || (paddr == ccr_pkg::OFS_STAT) ||
                  (paddr == ccr_pkg::OFS_RDATA) || (paddr == ccr_pkg::OFS_ISTAT) ||
                  (paddr == ccr_pkg::OFS_IMASK);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == ccr_pkg::OFS_STAT) begin
      rd_mux[ccr_pkg::STAT_BUSY]  = busy;
      rd_mux[ccr_pkg::STAT_HWSEC] = hwsec_r;
    end else if (paddr == ccr_pkg::OFS_RDATA) begin
      rd_mux[15:0] = rdata_r;
    end else if (paddr == ccr_pkg::OFS_ISTAT) begin
      rd_mux[ccr_pkg::IRQ_W-1:0] = istat_r;
    end else if (paddr == ccr_pkg::OFS_IMASK) begin
      rd_mux[ccr_pkg::IRQ_W-1:0] = imask_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ==========================================================================
  // Interrupt status and mask; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= '0;
      imask_r <= '0;
      irq     <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == ccr_pkg::OFS_ISTAT) begin
        istat_r <= (istat_r & ~pwdata[ccr_pkg::IRQ_W-1:0]) | ev_set;
      end else begin
        istat_r <= istat_r | ev_set;
      end
      if (acc && pwrite && paddr == ccr_pkg::OFS_IMASK) begin
        imask_r <= pwdata[ccr_pkg::IRQ_W-1:0];
      end
      irq <= |(istat_r & imask_r);
    end
  end

  // ==========================================================================
  // Link clock divider; the clock runs free and frames align to its rising edge.
  logic [7:0]             div_r;
  logic                   sclk_r;
  logic                   tick;
  logic                   rise_ev;
  logic                   fall_ev;

  assign tick    = (div_r == 8'(SCLK_HALF - 1));
  assign rise_ev = tick & ~sclk_r;
  assign fall_ev = tick & sclk_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= 8'h00;
      sclk_r <= 1'b0;
    end else if (tick) begin
      div_r  <= 8'h00;
      sclk_r <= ~sclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ==========================================================================
  // Frame engine.
  ccr_pkg::ccr_hstate_e   state_r;
  logic [15:0]            word_r;
  logic [15:0]            cmd_r;
  logic [15:0]            cap_r;
  logic [ccr_pkg::CNT_W-1:0] bit_r;
  logic                   pend_r;
  logic                   sec_r;
  logic                   fs_n_r;
  logic                   din_r;
  logic                   dout_s;
  logic                   last_fall;

  ccr_sync #(
    .W   (1),
    .RST (1'b0)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (link.dout_line),
    .q     (dout_s)
  );

  assign busy      = pend_r | (state_r != ccr_pkg::H_IDLE);
  assign last_fall = fall_ev & (state_r == ccr_pkg::H_RUN) &
                     (bit_r == ccr_pkg::CNT_W'(ccr_pkg::FRAME_BITS - 1));
  assign ev_set[ccr_pkg::IRQ_DONE]  = last_fall;
  assign ev_set[ccr_pkg::IRQ_RDATA] = last_fall & sec_r & cmd_r[ccr_pkg::RW_BIT];

  // A command written while a frame is pending or running is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ccr_pkg::H_IDLE;
      pend_r  <= 1'b0;
      sec_r   <= 1'b0;
      cmd_r   <= 16'h0000;
      word_r  <= 16'h0000;
      cap_r   <= 16'h0000;
      rdata_r <= 16'h0000;
      bit_r   <= '0;
      fs_n_r  <= 1'b1;
      din_r   <= 1'b0;
      hwsec_r <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == ccr_pkg::OFS_CMD && !busy) begin
        pend_r <= 1'b1;
        cmd_r  <= pwdata[15:0];
        word_r <= pwdata[15:0];
        sec_r  <= pwdata[ccr_pkg::CMD_SEC_BIT];
      end
      case (state_r)
        ccr_pkg::H_IDLE: begin
          if (pend_r && rise_ev) begin
            pend_r  <= 1'b0;
            fs_n_r  <= 1'b0;
            din_r   <= word_r[15];
            word_r  <= {word_r[14:0], 1'b0};
            bit_r   <= '0;
            state_r <= ccr_pkg::H_RUN;
          end
        end
        ccr_pkg::H_RUN: begin
          if (rise_ev) begin
            din_r  <= word_r[15];
            word_r <= {word_r[14:0], 1'b0};
          end else if (fall_ev) begin
            cap_r <= {cap_r[14:0], dout_s};
            bit_r <= bit_r + 5'h01;
            if (last_fall) begin
              rdata_r <= {cap_r[14:0], dout_s};
              state_r <= ccr_pkg::H_GAP;
              if (sec_r && !cmd_r[ccr_pkg::RW_BIT] &&
                  cmd_r[ccr_pkg::ADDR_MSB:ccr_pkg::ADDR_LSB] == ccr_pkg::ADDR_PRI) begin
                hwsec_r <= ~cmd_r[ccr_pkg::P_SRST] & cmd_r[ccr_pkg::P_HWSEC];
              end
            end
          end
        end
        ccr_pkg::H_GAP: begin
          // Frame sync rises with the next link clock rise, not with the last fall: the codec
          // sees both pins through equal synchronisers and must find sync still low at that fall.
          if (rise_ev) begin
            fs_n_r  <= 1'b1;
            state_r <= ccr_pkg::H_IDLE;
            sec_r   <= 1'b0;
          end
        end
        default: begin
          state_r <= ccr_pkg::H_IDLE;
        end
      endcase
    end
  end

  // The command word goes out as written, reserved bits included: address, direction and data.
  assign link.sclk    = sclk_r;
  assign link.fs_n    = fs_n_r;
  assign link.din     = din_r;
  assign link.sec_req = sec_r & ~fs_n_r;

endmodule
`default_nettype wire

// >>> ccr_link_chk.sv
// Checker of the serial link between the host end and the codec end.
`timescale 1ns/1ps
`default_nettype none
module ccr_link_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic fs_n,
  input wire logic din,
  input wire logic sec_req,
  input wire logic dout_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       sclk_q;
  logic [4:0] rise_r;
  // ====
  // Frame bit counter.
  // Counts link clock rises inside a frame; the idle level clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      rise_r <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (fs_n) rise_r <= 5'h00;
      else if (sclk && !sclk_q) rise_r <= rise_r + 5'h01;
    end
  end
  // ====
  // Properties.
  AST_FRAME_LEN: assert property ($rose(fs_n) |-> rise_r == 5'h10)
    else $error("frame not sixteen bits long");
  AST_FS_ON_RISE: assert property ($fell(fs_n) |-> $rose(sclk))
    else $error("frame start off the clock rise");
  AST_DIN_ON_RISE: assert property ((!fs_n && !$past(fs_n) && $changed(din)) |-> $rose(sclk))
    else $error("data bit moved off the clock rise");
  AST_SEC_STEADY: assert property ((!fs_n && !$past(fs_n)) |-> $stable(sec_req))
    else $error("frame kind changed inside a frame");
  AST_SEC_IDLE: assert property ((fs_n && $past(fs_n)) |-> !sec_req)
    else $error("frame kind high while idle");
  AST_OE_IDLE: assert property (fs_n [*6] |-> !dout_oe)
    else $error("codec drives output outside a frame");
  AST_OE_RISE: assert property ($rose(dout_oe) |-> !fs_n && !$past(fs_n, 2))
    else $error("codec drives output before frame start");
  AST_GAP: assert property ($rose(fs_n) |=> fs_n [*8])
    else $error("frames too close together");
  cover property ($fell(fs_n) && sec_req);
  cover property ($fell(fs_n) && !sec_req);
  cover property ($rose(dout_oe));
endmodule
`default_nettype wire

// >>> codec_control_register_set_tb.sv
// Self-checking bench of both ends joined over the serial link.
`timescale 1ns/1ps
`default_nettype none
module codec_control_register_set_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, er, msk, phone, srst, dv;
  logic        fir_ovf = 1'b0;
  logic [1:0]  flags = 2'h0;
  logic [15:0] adc = 16'h0;
  logic [15:0] dac, w;
  logic [6:0]  ctl;
  logic [7:0]  d;
  integer      seed = 98868;
  int          err_total = 0, checked = 0, sr_cnt = 0, cyc = 0, dv_cnt = 0;
  ccr_link_if link ();
  ccr_host i_ccr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link.host));
  ccr_dev i_ccr_dev (.pclk(pclk), .presetn(presetn), .link(link.dev), .fir_overflow(fir_ovf),
    .flag_level(flags), .adc_sample(adc), .power_down(ctl[6]), .adc_aux_sel(ctl[5]),
    .mon_aux_sel(ctl[4]), .mon_gain(ctl[3:2]), .loopback(ctl[1]), .hw_secondary(ctl[0]),
    .phone_mode(phone), .soft_reset(srst), .dac_sample(dac), .dac_valid(dv));
  ccr_link_chk i_ccr_link_chk (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
    .fs_n(link.fs_n), .din(link.din), .sec_req(link.sec_req), .dout_oe(link.dout_oe));
  // ====
  // Clock, pulse counter and hang guard.
  initial forever #5 pclk = ~pclk;
  // Long enough for over a hundred frames; a hang ends the run as a failure.
  always @(posedge pclk) begin
    cyc++;
    if (srst === 1'b1) sr_cnt++;
    if (dv === 1'b1) dv_cnt++;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end
  task test_done();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issues a frame, waits for its done flag, checks irq, then clears it.
  task frame(input logic s, input logic [15:0] x);
    apb(1'b1, 8'h00, {15'h0, s, x});
    do apb(1'b0, 8'h0c, 32'h0); while (rd[0] !== 1'b1);
    chk("irq", {31'h0, msk}, {31'h0, irq});
    apb(1'b1, 8'h0c, 32'h3);
    repeat (2) @(posedge pclk);
    chk("irq clr", 32'h0, {31'h0, irq});
  endtask
  task rdr(input logic [4:0] a);
    frame(1'b1, {3'h1, a, 8'h00});
    apb(1'b0, 8'h08, 32'h0);
  endtask
  // ====
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("ctl", 32'h0, {25'h0, ctl});
    chk("phone", 32'h0, {31'h0, phone});
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("bad rd", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      msk = ~i[0];
      apb(1'b1, 8'h10, {31'h0, msk});
      d = $random(seed);
      d[7] = 1'b0;
      if (i < 4) d[3:2] = i[1:0];
      frame(1'b1, {3'h0, 5'h01, d});
      chk("ctl", {25'h0, d[6:0]}, {25'h0, ctl});
      apb(1'b0, 8'h04, 32'h0);
      chk("stat", {30'h0, d[0], 1'b0}, rd);
      rdr(5'h01);
      chk("reg1", {24'h0, d}, {16'h0, rd[15:0]});
    end
    {fir_ovf, flags} <= $random(seed);
    frame(1'b1, {3'h0, 5'h02, 8'h3c});
    chk("phone", 32'h1, {31'h0, phone});
    rdr(5'h02);
    chk("reg2", {26'h0, fir_ovf, flags, 3'h4}, {16'h0, rd[15:0]});
    frame(1'b1, {3'h0, 5'h00, 8'hff});
    chk("ctl", {25'h0, d[6:0]}, {25'h0, ctl});
    rdr(5'h03);
    chk("reg3", 32'h0, {16'h0, rd[15:0]});
    sr_cnt = 0;
    frame(1'b1, {3'h0, 5'h01, 8'h80});
    chk("srst", 32'h1, sr_cnt);
    chk("ctl", 32'h0, {24'h0, ctl, phone});
    rdr(5'h01);
    chk("reg1", 32'h0, {16'h0, rd[15:0]});
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 16'h8000 : 16'($random(seed));
      adc <= $random(seed);
      dv_cnt = 0;
      frame(1'b0, w);
      chk("dac", {16'h0, w}, {16'h0, dac});
      chk("dac valid", 32'h1, dv_cnt);
      apb(1'b0, 8'h08, 32'h0);
      chk("adc", {16'h0, adc}, {16'h0, rd[15:0]});
    end
    test_done();
  end
endmodule
`default_nettype wire
